/* pls_lock_status.sv */
// module: lock threshold, calibration, status, event and unlock counter bank
`timescale 1ns/1ps
//
// Overview of operation
// - upper window code in bits 7:4, reset 8, sets high threshold.
// - lower window code in bits 3:0, reset 8, sets low threshold.
// - calibration status bit 6 reads 1 once calibration is finished.
// - calibration status bit 7 reads 1 when calibration failed.
// - six-bit calibrated band readable, valid once done reads 1.
// - real-time lock bit 0 reads 1 while locked.
// - real-time bit 2 high while control voltage rails high.
// - real-time bit 1 high while control voltage rails low.
// - rail-high event flag bit 2 set on rail-high condition.
// - rail-low event flag bit 1 set on rail-low condition.
// - loss-of-lock flag bit 0 set on each locked-to-unlocked change.
// - flags stay set until a one is written to their bit.
// - four-bit unlock counter counts each lock loss, saturates at 15.
// - writing the counter clears or presets it; counting continues.
// - precision enable, default set, selects the threshold window check.
//
module pls_lock_status #(
    parameter int BAND_W = pls_pkg::BAND_W
) (
    input wire logic clk_sys_in,                      // system clock 25 MHz
    input wire logic rst_n_in,                        // async reset, low
    input wire logic [pls_pkg::ADDR_W-1:0] addr_in,   // register address
    input wire logic [pls_pkg::DATA_W-1:0] wdata_in,  // write data
    input wire logic wr_in,                           // write strobe
    input wire logic rd_in,                           // read strobe
    output logic [pls_pkg::DATA_W-1:0] rdata_out,     // read data, next cycle
    input wire logic raw_lock_in,                     // coarse lock detector
    input wire logic above_upper_in,                  // vctrl above upper
    input wire logic below_lower_in,                  // vctrl below lower
    input wire logic cal_done_in,                     // calibration finished
    input wire logic cal_fail_in,                     // calibration failed
    input wire logic [BAND_W-1:0] cal_band_in,        // calibrated band
    output logic [3:0] upper_window_code_out,         // to upper comparator
    output logic [3:0] lower_window_code_out,         // to lower comparator
    output logic precision_en_out,                    // precision check on
    output logic lock_out                             // lock indication
);
    initial
    begin
        if (BAND_W < 1 || BAND_W > pls_pkg::CAL_DONE_BIT)
            $error("pls_lock_status: BAND_W out of range");
        if (pls_pkg::UPPER_MSB >= pls_pkg::DATA_W)
            $error("pls_lock_status: upper field outside data word");
        if (pls_pkg::UPPER_LSB != pls_pkg::LOWER_MSB + 1)
            $error("pls_lock_status: threshold fields not adjacent");
        if (pls_pkg::CAL_FAIL_BIT >= pls_pkg::DATA_W)
            $error("pls_lock_status: fail bit outside data word");
        if (pls_pkg::CAL_FAIL_BIT == pls_pkg::CAL_DONE_BIT)
            $error("pls_lock_status: fail and done bits overlap");
        if (pls_pkg::NUM_EVT > pls_pkg::DATA_W)
            $error("pls_lock_status: too many event flags");
        if (pls_pkg::RAIL_HIGH_BIT >= pls_pkg::NUM_EVT)
            $error("pls_lock_status: rail high flag outside events");
        if (pls_pkg::CNT_W > pls_pkg::DATA_W)
            $error("pls_lock_status: counter wider than data word");
        if (pls_pkg::PREC_EN_BIT >= pls_pkg::DATA_W)
            $error("pls_lock_status: enable bit outside data word");
    end

    localparam int SW = 5 + BAND_W;

    logic [SW-1:0] sync_d;
    logic [SW-1:0] sync_q;
    logic raw_lock_s;
    logic above_s;
    logic below_s;
    logic cal_done_s;
    logic cal_fail_s;
    logic [BAND_W-1:0] band_s;

    assign sync_d = {raw_lock_in, above_upper_in, below_lower_in,
                     cal_done_in, cal_fail_in, cal_band_in};

    pls_sync #(
        .WIDTH(SW)
    ) u_sync (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .d_in(sync_d),
        .q_out(sync_q)
    );

    assign {raw_lock_s, above_s, below_s, cal_done_s, cal_fail_s, band_s} =
        sync_q;

    logic [3:0] upper_r;
    logic [3:0] lower_r;
    logic prec_en_r;
    logic lock_r;
    logic rail_high_r;
    logic rail_low_r;
    logic [pls_pkg::NUM_EVT-1:0] evt_r;
    logic [pls_pkg::NUM_EVT-1:0] evt_set;
    logic [pls_pkg::NUM_EVT-1:0] evt_clr;
    logic [pls_pkg::CNT_W-1:0] cnt_r;
    logic lock_nxt;
    logic lock_fall;
    logic wr_thresh;
    logic wr_events;
    logic wr_cnt;
    logic wr_cfg;
    logic [pls_pkg::DATA_W-1:0] rd_nxt;
    logic [3:0] upper_nxt;
    logic [3:0] lower_nxt;
    logic prec_en_nxt;
    logic [pls_pkg::NUM_EVT-1:0] evt_nxt;
    logic [pls_pkg::CNT_W-1:0] cnt_nxt;
    logic [pls_pkg::DATA_W-1:0] thresh_word;
    logic [pls_pkg::DATA_W-1:0] cal_word;
    logic [pls_pkg::DATA_W-1:0] rt_word;
    logic [pls_pkg::DATA_W-1:0] evt_word;
    logic [pls_pkg::DATA_W-1:0] cnt_word;
    logic [pls_pkg::DATA_W-1:0] cfg_word;

    assign wr_thresh = wr_in && (addr_in == pls_pkg::OFF_THRESH);
    assign wr_events = wr_in && (addr_in == pls_pkg::OFF_EVENTS);
    assign wr_cnt = wr_in && (addr_in == pls_pkg::OFF_UNLOCK_CNT);
    assign wr_cfg = wr_in && (addr_in == pls_pkg::OFF_LOCK_CFG);

    // next threshold codes, both nibbles load from one write
    always_comb
    begin
        upper_nxt = upper_r;
        lower_nxt = lower_r;
        if (wr_thresh)
        begin
            upper_nxt = wdata_in[pls_pkg::UPPER_MSB:pls_pkg::UPPER_LSB];
            lower_nxt = wdata_in[pls_pkg::LOWER_MSB:pls_pkg::LOWER_LSB];
        end
    end

    // threshold codes
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            upper_r <= pls_pkg::UPPER_RST;
            lower_r <= pls_pkg::LOWER_RST;
        end
        else
        begin
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
        end
    end

    // next precision enable
    always_comb
    begin
        prec_en_nxt = prec_en_r;
        if (wr_cfg)
            prec_en_nxt = wdata_in[pls_pkg::PREC_EN_BIT];
    end

    // precision lock enable
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            prec_en_r <= pls_pkg::PREC_EN_RST;
        else
            prec_en_r <= prec_en_nxt;
    end

    // precision mode also requires vctrl inside the threshold window
    assign lock_nxt = raw_lock_s &&
        (!prec_en_r || (!above_s && !below_s));
    assign lock_fall = lock_r && !lock_nxt;

    // real-time lock status
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            lock_r <= 1'b0;
        else
            lock_r <= lock_nxt;
    end

    // real-time rail status
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rail_high_r <= 1'b0;
            rail_low_r <= 1'b0;
        end
        else
        begin
            rail_high_r <= above_s;
            rail_low_r <= below_s;
        end
    end

    // sticky event flags, a new event wins over a clear in the same cycle
    always_comb
    begin
        evt_set = '0;
        evt_set[pls_pkg::RAIL_HIGH_BIT] = above_s;
        evt_set[pls_pkg::RAIL_LOW_BIT] = below_s;
        evt_set[pls_pkg::LOCK_BIT] = lock_fall;
        evt_clr = wr_events ? wdata_in[pls_pkg::NUM_EVT-1:0] : '0;
    end

    generate
        for (genvar i = 0; i < pls_pkg::NUM_EVT; i++)
        begin : g_evt
            always_comb
            begin
                evt_nxt[i] = evt_r[i];
                if (evt_set[i])
                    evt_nxt[i] = 1'b1;
                else if (evt_clr[i])
                    evt_nxt[i] = 1'b0;
            end

            always_ff @(posedge clk_sys_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                    evt_r[i] <= 1'b0;
                else
                    evt_r[i] <= evt_nxt[i];
            end
        end
    endgenerate

    // next count, a write takes priority over a coincident count
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (wr_cnt)
            cnt_nxt = wdata_in[pls_pkg::CNT_W-1:0];
        else if (lock_fall && cnt_r != pls_pkg::CNT_MAX)
            cnt_nxt = cnt_r + 4'h1;
    end

    // unlock counter
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cnt_r <= pls_pkg::CNT_RST;
        else
            cnt_r <= cnt_nxt;
    end

    // read words per register, unused bits read zero
    always_comb
    begin
        thresh_word = '0;
        cal_word = '0;
        rt_word = '0;
        evt_word = '0;
        cnt_word = '0;
        cfg_word = '0;
        thresh_word[pls_pkg::UPPER_MSB:pls_pkg::UPPER_LSB] =
            upper_r;
        thresh_word[pls_pkg::LOWER_MSB:pls_pkg::LOWER_LSB] =
            lower_r;
        cal_word[pls_pkg::CAL_FAIL_BIT] = cal_fail_s;
        cal_word[pls_pkg::CAL_DONE_BIT] = cal_done_s;
        cal_word[BAND_W-1:0] = band_s;
        rt_word[pls_pkg::LOCK_BIT] = lock_r;
        rt_word[pls_pkg::RAIL_LOW_BIT] = rail_low_r;
        rt_word[pls_pkg::RAIL_HIGH_BIT] = rail_high_r;
        evt_word[pls_pkg::NUM_EVT-1:0] = evt_r;
        cnt_word[pls_pkg::CNT_W-1:0] = cnt_r;
        cfg_word[pls_pkg::PREC_EN_BIT] = prec_en_r;
    end

    // read mux
    always_comb
    begin
        rd_nxt = '0;
        case (addr_in)
            pls_pkg::OFF_THRESH:
                rd_nxt = thresh_word;
            pls_pkg::OFF_CAL_STS:
                rd_nxt = cal_word;
            pls_pkg::OFF_RT_STS:
                rd_nxt = rt_word;
            pls_pkg::OFF_EVENTS:
                rd_nxt = evt_word;
            pls_pkg::OFF_UNLOCK_CNT:
                rd_nxt = cnt_word;
            pls_pkg::OFF_LOCK_CFG:
                rd_nxt = cfg_word;
            default:
                rd_nxt = '0;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_out <= '0;
        else if (rd_in)
            rdata_out <= rd_nxt;
        else
            rdata_out <= '0;
    end

    // threshold codes to the window comparators
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            upper_window_code_out <= pls_pkg::UPPER_RST;
            lower_window_code_out <= pls_pkg::LOWER_RST;
        end
        else
        begin
            upper_window_code_out <= upper_r;
            lower_window_code_out <= lower_r;
        end
    end

    // precision enable to the lock detector
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            precision_en_out <= pls_pkg::PREC_EN_RST;
        else
            precision_en_out <= prec_en_r;
    end

    // lock indication, one cycle behind the status bit
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            lock_out <= 1'b0;
        else
            lock_out <= lock_r;
    end
endmodule // pls_lock_status

/* pls_lock_status_sva.sv */
// checker: port-level assertions for the lock status bank
`timescale 1ns/1ps
module pls_lock_status_sva (
    input wire logic clk_sys_in, // clock
    input wire logic rst_n_in, // reset
    input wire logic [3:0] addr_in, // address
    input wire logic [7:0] wdata_in, // write data
    input wire logic wr_in, // write
    input wire logic rd_in, // read
    input wire logic [7:0] rdata_out, // read data
    input wire logic raw_lock_in, // lock
    input wire logic cal_done_in, // cal done
    input wire logic [3:0] upper_window_code_out, // upper
    input wire logic [3:0] lower_window_code_out, // lower
    input wire logic precision_en_out, // precision
    input wire logic lock_out // lock
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not zero without a read");
    AST_UP_WR: assert property (wr_in && addr_in == 4'h0 |=> ##1
        upper_window_code_out == $past(wdata_in[7:4], 2))
        else $error("upper code not loaded");
    AST_LO_WR: assert property (wr_in && addr_in == 4'h0 |=> ##1
        lower_window_code_out == $past(wdata_in[3:0], 2))
        else $error("lower code not loaded");
    AST_CODE_HOLD: assert property (!(wr_in && addr_in == 4'h0) |-> ##2
        $stable(upper_window_code_out) && $stable(lower_window_code_out))
        else $error("codes changed without a write");
    AST_PREC_WR: assert property (wr_in && addr_in == 4'h5 |=> ##1
        precision_en_out == $past(wdata_in[0], 2))
        else $error("precision enable not loaded");
    AST_NO_LOCK: assert property (!raw_lock_in [*6] |-> !lock_out)
        else $error("lock shown without raw lock");
    AST_UNMAPPED: assert property (rd_in && addr_in > 4'h5 |=>
        rdata_out == 8'h00)
        else $error("unmapped read not zero");
    AST_STS_RSV: assert property (rd_in && addr_in == 4'h2 |=>
        rdata_out[7:3] == 5'h00)
        else $error("status upper bits not zero");
    AST_EVT_RSV: assert property (rd_in && addr_in == 4'h3 |=>
        rdata_out[7:3] == 5'h00)
        else $error("event upper bits not zero");
    AST_CNT_RSV: assert property (rd_in && addr_in == 4'h4 |=>
        rdata_out[7:4] == 4'h0)
        else $error("counter upper bits not zero");
    AST_CAL_BUSY: assert property (!cal_done_in [*6] ##0
        (rd_in && addr_in == 4'h1) |=> !rdata_out[6])
        else $error("done shown while calibrating");
    COV_LOCK: cover property ($rose(lock_out));
    COV_LOSS: cover property ($fell(lock_out));
    COV_CNT_WR: cover property (wr_in && addr_in == 4'h4);
endmodule // pls_lock_status_sva
bind pls_lock_status pls_lock_status_sva i_sva (.clk_sys_in, .rst_n_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .raw_lock_in,
    .cal_done_in, .upper_window_code_out, .lower_window_code_out,
    .precision_en_out, .lock_out);

/* pls_lock_status_tb.sv */
// testbench: register accesses and status pin stimulus for the lock bank
`timescale 1ns/1ps
module pls_lock_status_tb;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic raw_lock_in = 1'b0;
    logic above_upper_in = 1'b0;
    logic below_lower_in = 1'b0;
    logic cal_done_in = 1'b0;
    logic cal_fail_in = 1'b0;
    logic [5:0] cal_band_in = 6'h2a;
    logic [7:0] rdata_out;
    logic [3:0] upper_window_code_out;
    logic [3:0] lower_window_code_out;
    logic precision_en_out;
    logic lock_out;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    always #20 clk_sys_in = ~clk_sys_in;
    pls_lock_status i_dut (.clk_sys_in, .rst_n_in, .addr_in, .wdata_in,
        .wr_in, .rd_in, .rdata_out, .raw_lock_in, .above_upper_in,
        .below_lower_in, .cal_done_in, .cal_fail_in, .cal_band_in,
        .upper_window_code_out, .lower_window_code_out, .precision_en_out,
        .lock_out);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, exp);
    endtask
    // drive the analog status levels, then let the synchronisers settle
    task automatic pins(input logic l, input logic h, input logic lo);
        @(posedge clk_sys_in);
        raw_lock_in <= l;
        above_upper_in <= h;
        below_lower_in <= lo;
        repeat (6) @(posedge clk_sys_in);
    endtask
    task automatic lose();
        pins(1'b1, 1'b0, 1'b0);
        pins(1'b0, 1'b0, 1'b0);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd(4'h0, 8'h88);
        rd(4'h5, 8'h01);
        rd(4'h4, 8'h00);
        rd(4'h3, 8'h00);
        rd(4'h7, 8'h00);
        rd(4'h1, 8'h2a);
        $display("test reset values done");
        wr(4'h0, 8'h3c);
        rd(4'h0, 8'h3c);
        chk({upper_window_code_out, lower_window_code_out}, 8'h3c);
        wr(4'h1, 8'hff);
        cal_done_in <= 1'b1;
        cal_fail_in <= 1'b1;
        pins(1'b0, 1'b0, 1'b0);
        rd(4'h1, 8'hea);
        cal_fail_in <= 1'b0;
        pins(1'b0, 1'b0, 1'b0);
        rd(4'h1, 8'h6a);
        $display("test thresholds and calibration done");
        pins(1'b1, 1'b0, 1'b0);
        rd(4'h2, 8'h01);
        chk({7'h00, lock_out}, 8'h01);
        pins(1'b1, 1'b1, 1'b0);
        rd(4'h2, 8'h04);
        rd(4'h3, 8'h05);
        rd(4'h4, 8'h01);
        pins(1'b1, 1'b0, 1'b1);
        rd(4'h2, 8'h02);
        rd(4'h3, 8'h07);
        wr(4'h3, 8'h04);
        rd(4'h3, 8'h03);
        wr(4'h3, 8'h00);
        rd(4'h3, 8'h03);
        pins(1'b0, 1'b0, 1'b0);
        wr(4'h3, 8'h07);
        rd(4'h3, 8'h00);
        $display("test status and events done");
        wr(4'h5, 8'h00);
        @(posedge clk_sys_in);
        #1 chk({7'h00, precision_en_out}, 8'h00);
        pins(1'b1, 1'b1, 1'b0);
        rd(4'h2, 8'h05);
        wr(4'h5, 8'h01);
        pins(1'b1, 1'b1, 1'b0);
        rd(4'h2, 8'h04);
        rd(4'h4, 8'h02);
        pins(1'b0, 1'b0, 1'b0);
        $display("test precision window done");
        wr(4'h4, 8'h0e);
        lose();
        rd(4'h4, 8'h0f);
        lose();
        rd(4'h4, 8'h0f);
        wr(4'h4, 8'h00);
        rd(4'h4, 8'h00);
        wr(4'h4, 8'h05);
        lose();
        rd(4'h4, 8'h06);
        $display("test unlock counter done");
        tally_and_finish();
    end
endmodule // pls_lock_status_tb

/* pls_pkg.sv */
// package: register map, field layout and reset values of the lock status bank
package pls_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [3:0] OFF_THRESH = 4'h0;
    localparam logic [3:0] OFF_CAL_STS = 4'h1;
    localparam logic [3:0] OFF_RT_STS = 4'h2;
    localparam logic [3:0] OFF_EVENTS = 4'h3;
    localparam logic [3:0] OFF_UNLOCK_CNT = 4'h4;
    localparam logic [3:0] OFF_LOCK_CFG = 4'h5;
    // threshold fields
    localparam int UPPER_MSB = 7;
    localparam int UPPER_LSB = 4;
    localparam int LOWER_MSB = 3;
    localparam int LOWER_LSB = 0;
    localparam logic [3:0] UPPER_RST = 4'h8;
    localparam logic [3:0] LOWER_RST = 4'h8;
    // calibration status fields
    localparam int CAL_FAIL_BIT = 7;
    localparam int CAL_DONE_BIT = 6;
    localparam int BAND_W = 6;
    // status and event bit positions
    localparam int LOCK_BIT = 0;
    localparam int RAIL_LOW_BIT = 1;
    localparam int RAIL_HIGH_BIT = 2;
    localparam int NUM_EVT = 3;
    // counter
    localparam int CNT_W = 4;
    localparam logic [3:0] CNT_MAX = 4'hf;
    localparam logic [3:0] CNT_RST = 4'h0;
    // precision lock enable lives in bit 0 of the lock config register
    localparam int PREC_EN_BIT = 0;
    localparam logic PREC_EN_RST = 1'b1;
endpackage

/* pls_sync.sv */
// module: two flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
module pls_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,              // system clock
    input wire logic rst_n_in,            // async reset, active low
    input wire logic [WIDTH-1:0] d_in,    // asynchronous levels
    output logic [WIDTH-1:0] q_out        // synchronised levels
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_r <= '0;
            q_out <= '0;
        end
        else
        begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule // pls_sync
